// *** verilog/relay_pkg.sv ***
// Shared constants and types for the relay record and diagnosis block.
// Assumes one system clock; loss of auxiliary power appears as the reset.
package relay_pkg;

  localparam int NUM_OUT           = 6;
  localparam int NUM_PHASE         = 3;
  localparam int CUR_W             = 16;
  localparam int RATIO_W           = 8;
  localparam int SAMPLE_W          = 16;
  localparam int FAULT_DEPTH       = 5;
  localparam int SLOT_W            = 3;
  localparam int FIRST_ENTRY_ITEM  = 211;
  localparam int LAST_ENTRY_ITEM   = 215;

  // Waveform sampling and storage.
  localparam int SAMPLE_ANGLE_DEG  = 30;
  localparam int SAMPLES_PER_CYCLE = 360 / SAMPLE_ANGLE_DEG;
  localparam int STORE_CYCLES      = 224;
  localparam int STORE_POINTS      = STORE_CYCLES * SAMPLES_PER_CYCLE;
  localparam int MAX_PRE_CYCLES    = 224;
  localparam int MAX_POST_CYCLES   = 224;
  localparam int CYC_W             = 8;
  localparam int PTR_W             = 12;
  localparam int MEM_AW            = 14;

  // Self-diagnosis checks, one bit each, with their four-digit codes.
  localparam int NUM_CHECKS        = 21;
  localparam int CODE_W            = 16;
  localparam logic [NUM_CHECKS*CODE_W-1:0] CODE_TABLE = {
    16'h0032, 16'h0031, 16'h0030, 16'h0029, 16'h0028, 16'h0017, 16'h0016,
    16'h0015, 16'h0014, 16'h0013, 16'h0012, 16'h0011, 16'h0010, 16'h0009,
    16'h0008, 16'h0006, 16'h0005, 16'h0004, 16'h0003, 16'h0002, 16'h0001};
  localparam logic [NUM_CHECKS-1:0] NONLOCK_MASK = 21'h1e0000;
  localparam logic [NUM_CHECKS-1:0] CARD_MASK    = 21'h1f0000;
  localparam logic [NUM_CHECKS-1:0] DI_MASK      = 21'h000400;
  localparam logic [NUM_CHECKS-1:0] ALL_CHECKS   = 21'h1fffff;

  typedef struct packed {
    logic [CUR_W-1:0]   cur;
    logic [RATIO_W-1:0] second_harmonic_ratio;
  } meas_s;

  typedef struct packed {
    logic             valid;
    logic [PTR_W-1:0] start;
    logic [PTR_W-1:0] len;
  } wave_desc_s;

  typedef enum logic {CAP_RING, CAP_POST} cap_state_e;

endpackage

// *** verilog/relay_record_diag.sv ***
// Supervisory record and diagnosis logic of a protection relay: forced
// outputs, measurement display, maximum and fault records, waveform
// capture and self-diagnosis. Assumes all inputs come from logic on
// clock_i, and that reset_n_i low means auxiliary power is absent.
//
// Functional notes
// - Each of six outputs forceable independently.
// - Lamps show state of forced outputs.
// - Present per-phase current and second-harmonic ratio.
// - Keep per-phase largest current seen.
// - Power loss or command clears maxima.
// - Protection output stores currents and waveform.
// - Five entries, newest first, oldest dropped.
// - Power loss drops waveforms, keeps fault currents.
// - Fault clear erases currents and waveforms.
// - Waveforms captured only with card fitted.
// - Sample every 30 degrees, twelve per cycle.
// - Entry holds at most 224 cycles.
// - Window from 224 before to 224 after.
// - Abnormality locks outputs, drops run, closes alarm.
// - Each check failure records its four-digit defect code; power fault records none.
// - Power cycle resets failure, keeps defect codes.
// - Codes accumulate until alarm clear command.
// - Switch errors log code without locking.
// - Card and input checks only where fitted.
// - Halted processor needs no explicit output lock.
`timescale 1ns/1ps

module relay_record_diag #(
  parameter bit                                    DI_FITTED    = 1'b1,
  parameter logic [relay_pkg::NUM_CHECKS-1:0]      CHECK_ENABLE = relay_pkg::ALL_CHECKS
) (
  // Clock and reset
  input  wire logic                                          clock_i,
  input  wire logic                                          reset_n_i,
  // Protection elements
  input  wire logic [relay_pkg::NUM_OUT-1:0]                 prot_out_i,
  input  wire logic                                          fault_i,
  // Forced operation
  input  wire logic [relay_pkg::NUM_OUT-1:0]                 force_i,
  // Measurement datapath
  input  wire logic                                          meas_valid_i,
  input  relay_pkg::meas_s [relay_pkg::NUM_PHASE-1:0]        meas_i,
  input  wire logic                                          sample_tick_i,
  input  wire logic [relay_pkg::NUM_PHASE-1:0][relay_pkg::SAMPLE_W-1:0] sample_i,
  // Configuration
  input  wire logic                                          card_present_i,
  input  wire logic [relay_pkg::CYC_W-1:0]                   pre_cycles_i,
  input  wire logic [relay_pkg::CYC_W-1:0]                   post_cycles_i,
  // Commands
  input  wire logic                                          max_clear_i,
  input  wire logic                                          fault_clear_i,
  input  wire logic                                          alarm_clear_i,
  // Self-diagnosis inputs
  input  wire logic [relay_pkg::NUM_CHECKS-1:0]              check_fail_i,
  input  wire logic                                          power_fault_i,
  // Waveform read port
  input  wire logic [relay_pkg::SLOT_W-1:0]                  wave_rd_entry_i,
  input  wire logic [relay_pkg::PTR_W-1:0]                   wave_rd_idx_i,
  // Contacts and lamps
  output logic      [relay_pkg::NUM_OUT-1:0]                 contact_o,
  output logic      [relay_pkg::NUM_OUT-1:0]                 lamp_o,
  output logic                                               run_lamp_o,
  output logic                                               alarm_contact_o,
  output logic                                               lock_o,
  // Records
  output relay_pkg::meas_s [relay_pkg::NUM_PHASE-1:0]        meas_o,
  output logic [relay_pkg::NUM_PHASE-1:0][relay_pkg::CUR_W-1:0] max_cur_o,
  output logic [relay_pkg::FAULT_DEPTH-1:0][relay_pkg::NUM_PHASE-1:0][relay_pkg::CUR_W-1:0]
                                                             fault_cur_o,
  output logic      [relay_pkg::FAULT_DEPTH-1:0]             wave_valid_o,
  output logic      [relay_pkg::PTR_W-1:0]                   wave_len_o,
  output logic [relay_pkg::NUM_PHASE-1:0][relay_pkg::SAMPLE_W-1:0] wave_rd_o,
  // Diagnosis record
  output logic      [relay_pkg::NUM_CHECKS-1:0]              defect_flags_o,
  output logic      [relay_pkg::CODE_W-1:0]                  defect_code_o
);

  localparam int NP = relay_pkg::NUM_PHASE;
  localparam int ND = relay_pkg::FAULT_DEPTH;
  localparam int PW = relay_pkg::PTR_W;
  localparam logic [PW-1:0] POINTS = PW'(relay_pkg::STORE_POINTS);
  localparam logic [PW-1:0] SPC    = PW'(relay_pkg::SAMPLES_PER_CYCLE);
  localparam logic [relay_pkg::CYC_W-1:0] MAX_PRE   = relay_pkg::CYC_W'(relay_pkg::MAX_PRE_CYCLES);
  localparam logic [relay_pkg::CYC_W-1:0] MAX_POST  = relay_pkg::CYC_W'(relay_pkg::MAX_POST_CYCLES);
  localparam logic [relay_pkg::CYC_W-1:0] CAP_CYCLES = relay_pkg::CYC_W'(relay_pkg::STORE_CYCLES);
  localparam logic [relay_pkg::SLOT_W-1:0] LAST_SLOT = relay_pkg::SLOT_W'(ND - 1);

  // Reset release through two flip-flops.
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  function automatic logic [relay_pkg::SLOT_W-1:0] slot_dec(
    input logic [relay_pkg::SLOT_W-1:0] s);
    slot_dec = (s == '0) ? LAST_SLOT : s - 1'b1;
  endfunction

  function automatic logic [PW-1:0] ptr_wrap(input logic [PW:0] p);
    ptr_wrap = (p >= {1'b0, POINTS}) ? PW'(p - {1'b0, POINTS}) : p[PW-1:0];
  endfunction

  // Self-diagnosis: check masking, failure state and the defect record.
  logic [relay_pkg::NUM_CHECKS-1:0] check_en;
  logic [relay_pkg::NUM_CHECKS-1:0] check_act;
  logic                             fail_reg, fail_next;
  logic [relay_pkg::NUM_CHECKS-1:0] defect_reg, defect_next;
  logic [relay_pkg::CODE_W-1:0]     code_next;

  always_comb begin
    check_en = CHECK_ENABLE;
    if (!card_present_i) begin
      check_en = check_en & ~relay_pkg::CARD_MASK;
    end
    if (!DI_FITTED) begin
      check_en = check_en & ~relay_pkg::DI_MASK;
    end
    check_act = check_fail_i & check_en;
    // Switch errors are logged only and never raise the failure state.
    fail_next = fail_reg | power_fault_i | (|(check_act & ~relay_pkg::NONLOCK_MASK));
    // A processor halt needs no term here: a stopped processor drives nothing.
    if (alarm_clear_i) begin
      defect_next = check_act;
    end else begin
      defect_next = defect_reg | check_act;
    end
    code_next = '0;
    for (int i = relay_pkg::NUM_CHECKS - 1; i >= 0; i--) begin
      if (defect_reg[i]) begin
        code_next = relay_pkg::CODE_TABLE[i*relay_pkg::CODE_W +: relay_pkg::CODE_W];
      end
    end
  end

  // Failure state follows power; the defect record does not.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      fail_reg <= 1'b0;
    end else begin
      fail_reg <= fail_next;
    end
  end

  // Defect flags are retained memory: no reset, cleared only by command.
  always_ff @(posedge clock_i) begin
    defect_reg    <= defect_next;
    defect_code_o <= code_next;
  end
  assign defect_flags_o = defect_reg;

  // Contacts, lamps, live measurement and per-phase maxima.
  logic [relay_pkg::NUM_OUT-1:0]                 contact_next;
  logic [NP-1:0][relay_pkg::CUR_W-1:0]           max_reg, max_next;
  relay_pkg::meas_s [NP-1:0]                     meas_reg, meas_next;

  always_comb begin
    // Forcing is ORed per bit, so no output depends on another.
    contact_next = fail_next ? '0 : (prot_out_i | force_i);
    meas_next    = meas_valid_i ? meas_i : meas_reg;
    for (int p = 0; p < NP; p++) begin
      max_next[p] = max_clear_i ? '0 : max_reg[p];
      if (meas_valid_i && (meas_i[p].cur > max_next[p])) begin
        max_next[p] = meas_i[p].cur;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      contact_o       <= '0;
      lamp_o          <= '0;
      run_lamp_o      <= 1'b0;
      alarm_contact_o <= 1'b1;
      lock_o          <= 1'b1;
      meas_reg        <= '0;
      max_reg         <= '0;
    end else begin
      contact_o       <= contact_next;
      lamp_o          <= contact_next;
      run_lamp_o      <= ~fail_next;
      alarm_contact_o <= fail_next;
      lock_o          <= fail_next;
      meas_reg        <= meas_next;
      max_reg         <= max_next;
    end
  end
  assign meas_o    = meas_reg;
  assign max_cur_o = max_reg;

  // Fault current record.
  logic [ND-1:0][NP-1:0][relay_pkg::CUR_W-1:0] fcur_reg, fcur_next;

  always_comb begin
    fcur_next = fault_clear_i ? '0 : fcur_reg;
    if (fault_i) begin
      // Shift toward the oldest slot; the oldest entry falls off.
      for (int e = ND - 1; e > 0; e--) begin
        fcur_next[e] = fcur_next[e-1];
      end
      for (int p = 0; p < NP; p++) begin
        fcur_next[0][p] = meas_i[p].cur;
      end
    end
  end

  // Retained across power loss, so this group has no reset.
  always_ff @(posedge clock_i) begin
    fcur_reg <= fcur_next;
  end
  assign fault_cur_o = fcur_reg;

  // Waveform capture.
  relay_pkg::cap_state_e                   cap_reg, cap_next;
  logic [PW-1:0]                           wr_ptr_reg, wr_ptr_next;
  logic [PW-1:0]                           fill_reg, fill_next;
  logic [PW-1:0]                           post_reg, post_next;
  logic [PW-1:0]                           pre_len_reg, pre_len_next;
  logic [relay_pkg::SLOT_W-1:0]            head_reg, head_next;
  logic [relay_pkg::SLOT_W-1:0]            cap_slot_reg, cap_slot_next;
  relay_pkg::wave_desc_s [ND-1:0]          desc_reg, desc_next;
  logic                                    mem_we;
  logic [relay_pkg::SLOT_W-1:0]            wr_slot;
  logic [relay_pkg::CYC_W-1:0]             pre_cyc, post_cyc;
  logic [PW-1:0]                           pre_pts, post_pts, end_ptr;

  always_comb begin
    // Clamp the window into the permitted range and the storage capacity.
    pre_cyc  = (pre_cycles_i > MAX_PRE) ? MAX_PRE : pre_cycles_i;
    post_cyc = (post_cycles_i > MAX_POST) ? MAX_POST : post_cycles_i;
    if (post_cyc > CAP_CYCLES - pre_cyc) begin
      post_cyc = CAP_CYCLES - pre_cyc;
    end
    pre_pts  = PW'(pre_cyc) * SPC;
    post_pts = PW'(post_cyc) * SPC;
    cap_next      = cap_reg;
    wr_ptr_next   = wr_ptr_reg;
    fill_next     = fill_reg;
    post_next     = post_reg;
    pre_len_next  = pre_len_reg;
    head_next     = head_reg;
    cap_slot_next = cap_slot_reg;
    desc_next     = desc_reg;
    wr_slot       = (cap_reg == relay_pkg::CAP_POST) ? cap_slot_reg : slot_dec(head_reg);
    mem_we        = sample_tick_i && card_present_i;
    end_ptr       = ptr_wrap({1'b0, wr_ptr_reg} + 1'b1);
    if (mem_we) begin
      wr_ptr_next = end_ptr;
      if (fill_reg != POINTS) begin
        fill_next = fill_reg + 1'b1;
      end
    end
    unique case (cap_reg)
      relay_pkg::CAP_RING: begin
        if (fault_i) begin
          head_next              = slot_dec(head_reg);
          desc_next[head_next].valid = 1'b0;
          if (card_present_i) begin
            cap_slot_next = head_next;
            // Holds the whole window length: the pre part found now plus the post part.
            pre_len_next  = ((fill_next < pre_pts) ? fill_next : pre_pts) + post_pts;
            post_next     = post_pts;
            cap_next      = relay_pkg::CAP_POST;
          end
        end
      end
      relay_pkg::CAP_POST: begin
        if (fault_i) begin
          // A second trip during a capture keeps its currents but no waveform.
          head_next                  = slot_dec(head_reg);
          desc_next[head_next].valid = 1'b0;
        end
        if (post_reg == '0 || (mem_we && post_reg == PW'(1))) begin
          desc_next[cap_slot_reg].valid = 1'b1;
          desc_next[cap_slot_reg].len   = pre_len_reg;
          // A tick in a zero-length post part lands outside the window.
          desc_next[cap_slot_reg].start = ptr_wrap(
            {1'b0, (post_reg == '0) ? wr_ptr_reg : end_ptr} + {1'b0, POINTS}
            - {1'b0, desc_next[cap_slot_reg].len});
          wr_ptr_next = '0;
          fill_next   = '0;
          cap_next    = relay_pkg::CAP_RING;
        end else if (mem_we) begin
          post_next = post_reg - 1'b1;
        end
      end
    endcase
    if (fault_clear_i) begin
      for (int e = 0; e < ND; e++) begin
        desc_next[e].valid = 1'b0;
      end
      // Only a capture already running is dropped; a trip in this cycle still records.
      cap_next = (cap_reg == relay_pkg::CAP_POST) ? relay_pkg::CAP_RING : cap_next;
    end
  end

  // Power loss invalidates every waveform.
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      cap_reg      <= relay_pkg::CAP_RING;
      wr_ptr_reg   <= '0;
      fill_reg     <= '0;
      post_reg     <= '0;
      pre_len_reg  <= '0;
      head_reg     <= '0;
      cap_slot_reg <= '0;
      desc_reg     <= '0;
    end else begin
      cap_reg      <= cap_next;
      wr_ptr_reg   <= wr_ptr_next;
      fill_reg     <= fill_next;
      post_reg     <= post_next;
      pre_len_reg  <= pre_len_next;
      head_reg     <= head_next;
      cap_slot_reg <= cap_slot_next;
      desc_reg     <= desc_next;
    end
  end

  // Waveform storage and read-out.
  logic [relay_pkg::SLOT_W-1:0]   rd_slot;
  logic [relay_pkg::MEM_AW-1:0]   wr_addr, rd_addr;
  logic [PW:0]                    rd_sum;

  always_comb begin
    rd_slot = ptr_wrap_slot(head_reg, wave_rd_entry_i);
    rd_sum  = {1'b0, desc_reg[rd_slot].start} + {1'b0, wave_rd_idx_i};
    rd_addr = relay_pkg::MEM_AW'(rd_slot) * relay_pkg::MEM_AW'(POINTS)
              + relay_pkg::MEM_AW'(ptr_wrap(rd_sum));
    wr_addr = relay_pkg::MEM_AW'(wr_slot) * relay_pkg::MEM_AW'(POINTS)
              + relay_pkg::MEM_AW'(wr_ptr_reg);
  end

  function automatic logic [relay_pkg::SLOT_W-1:0] ptr_wrap_slot(
    input logic [relay_pkg::SLOT_W-1:0] h, input logic [relay_pkg::SLOT_W-1:0] e);
    logic [relay_pkg::SLOT_W:0] s;
    s = {1'b0, h} + {1'b0, e};
    ptr_wrap_slot = (s > {1'b0, LAST_SLOT}) ? relay_pkg::SLOT_W'(s - ND) : s[relay_pkg::SLOT_W-1:0];
  endfunction

  // One sample array per phase; sample contents are not reset.
  for (genvar p = 0; p < NP; p++) begin : g_phase
    logic [relay_pkg::SAMPLE_W-1:0] mem [ND * relay_pkg::STORE_POINTS];
    always_ff @(posedge clock_i) begin
      if (mem_we) begin
        mem[wr_addr] <= sample_i[p];
      end
      wave_rd_o[p] <= mem[rd_addr];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      wave_valid_o <= '0;
      wave_len_o   <= '0;
    end else begin
      for (int e = 0; e < ND; e++) begin
        wave_valid_o[e] <= desc_reg[ptr_wrap_slot(head_reg, relay_pkg::SLOT_W'(e))].valid;
      end
      wave_len_o <= desc_reg[rd_slot].valid ? desc_reg[rd_slot].len : '0;
    end
  end

endmodule

// *** test/relay_far_end.sv ***
// Far-end model of the measurement front end feeding the waveform sampler.
// Assumes one sample tick every TICK_GAP system clocks stands for 30 degrees.
`timescale 1ns/1ps
module relay_far_end #(
  parameter int TICK_GAP = 4
) (
  // Clock
  input  wire logic         clock_i,
  // Sample stream
  output logic              tick_o,
  output logic [2:0][15:0]  sample_o
);
  int          gap_cnt;
  logic [15:0] seq;
  initial begin
    gap_cnt = 0;
    seq = 16'h0000;
    tick_o = 1'b0;
    sample_o = '0;
  end
  // Between ticks the samples toggle each clock, so stale data equals the last fresh sample on every second clock.
  always @(negedge clock_i) begin
    gap_cnt <= (gap_cnt == TICK_GAP - 1) ? 0 : gap_cnt + 1;
    tick_o <= (gap_cnt == 0);
    if (gap_cnt == 0) begin
      seq <= seq + 16'h0001;
      for (int p = 0; p < 3; p++) begin
        sample_o[p] <= seq + 16'(p);
      end
    end else begin
      sample_o <= ~sample_o;
    end
  end
endmodule

// *** test/relay_record_diag_monitor.sv ***
// Checker for the relay record and diagnosis block, bound to its top module.
// Assumes one clock and a two-flop reset release inside the block.
`timescale 1ns/1ps
module relay_record_diag_monitor #(
  parameter bit          DI_FITTED    = 1'b1,
  parameter logic [20:0] CHECK_ENABLE = relay_pkg::ALL_CHECKS
) (
  // Clock and reset
  input wire logic                  clock_i,
  input wire logic                  reset_n_i,
  // Block inputs
  input wire logic [5:0]            prot_out_i,
  input wire logic [5:0]            force_i,
  input wire logic                  fault_i,
  input relay_pkg::meas_s [2:0]     meas_i,
  input wire logic                  card_present_i,
  input wire logic                  fault_clear_i,
  input wire logic                  alarm_clear_i,
  input wire logic [20:0]           check_fail_i,
  input wire logic                  power_fault_i,
  // Block outputs
  input wire logic [5:0]            contact_o,
  input wire logic [5:0]            lamp_o,
  input wire logic                  run_lamp_o,
  input wire logic                  alarm_contact_o,
  input wire logic                  lock_o,
  input wire logic [4:0][2:0][15:0] fault_cur_o,
  input wire logic [4:0]            wave_valid_o,
  input wire logic [20:0]           defect_flags_o,
  input wire logic [15:0]           defect_code_o
);
  logic [1:0]  up_reg;
  logic [20:0] live_fail;
  // Checks wait until the internal reset copy has been released.
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end
  assign live_fail = check_fail_i & CHECK_ENABLE
                   & (card_present_i ? relay_pkg::ALL_CHECKS : ~relay_pkg::CARD_MASK)
                   & (DI_FITTED ? relay_pkg::ALL_CHECKS : ~relay_pkg::DI_MASK);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (up_reg != 2'h3);

  contact_cause_a: assert property (
    !lock_o |-> contact_o == ($past(prot_out_i) | $past(force_i))) else $error("contact wrong");
  locked_quiet_a: assert property (lock_o |-> contact_o == 6'h00) else $error("locked output");
  lamp_mirror_a: assert property (lamp_o == contact_o) else $error("lamp mismatch");
  status_pair_a: assert property (
    run_lamp_o == !lock_o && alarm_contact_o == lock_o) else $error("run or alarm wrong");
  power_lock_a: assert property (power_fault_i |=> lock_o) else $error("no power lock");
  check_lock_a: assert property (
    |(live_fail & ~relay_pkg::NONLOCK_MASK) |=> lock_o [*2]) else $error("no check lock");
  flag_log_a: assert property (
    |live_fail |=> (defect_flags_o & $past(live_fail)) == $past(live_fail))
    else $error("defect not logged");
  alarm_wipe_a: assert property (
    alarm_clear_i && live_fail == 21'h0 |=> defect_flags_o == 21'h0) else $error("flags kept");
  code_lowest_a: assert property (
    defect_flags_o[0] |=> defect_code_o == 16'h0001) else $error("code wrong");
  fault_push_a: assert property (fault_i && !fault_clear_i |=> fault_cur_o ==
    {$past(fault_cur_o[3:0]), $past(meas_i[2].cur), $past(meas_i[1].cur), $past(meas_i[0].cur)})
    else $error("fault entry wrong");
  fault_wipe_a: assert property (
    fault_clear_i && !fault_i |=> fault_cur_o == 240'h0) else $error("fault record kept");
  nocard_wave_a: assert property (
    fault_i && !card_present_i |=> ##1 !wave_valid_o[0]) else $error("wave without card");
  cover property (fault_i && card_present_i);
  cover property (defect_flags_o[17] && !lock_o);
  cover property (lock_o && force_i != 6'h00);
endmodule

bind relay_record_diag relay_record_diag_monitor #(
  .DI_FITTED   (DI_FITTED),
  .CHECK_ENABLE(CHECK_ENABLE)
) mon_u (.*);

// *** test/relay_record_and_diagnosis_tb.sv ***
// Self-checking testbench for the relay record and diagnosis block.
// Assumes the far-end model supplies the waveform sample stream.
`timescale 1ns/1ps
module relay_record_and_diagnosis_tb;
  logic                   clock_i, reset_n_i, fault_i, meas_valid_i, sample_tick_i;
  logic                   card_present_i, max_clear_i, fault_clear_i, alarm_clear_i;
  logic                   power_fault_i, run_lamp_o, alarm_contact_o, lock_o;
  logic [5:0]             prot_out_i, force_i, contact_o, lamp_o;
  logic [7:0]             pre_cycles_i, post_cycles_i;
  logic [20:0]            check_fail_i, defect_flags_o;
  logic [2:0]             wave_rd_entry_i;
  logic [11:0]            wave_rd_idx_i, wave_len_o;
  logic [4:0]             wave_valid_o;
  logic [15:0]            defect_code_o;
  logic [2:0][15:0]       sample_i, wave_rd_o, max_cur_o, exp_max, exp_w;
  logic [4:0][2:0][15:0]  fault_cur_o, exp_f;
  relay_pkg::meas_s [2:0] meas_i, meas_o;
  int                     fail_count, checks, cycles, n;
  int                     pre_t[3] = '{1, 0, 2};
  int                     post_t[3] = '{1, 2, 0};

  relay_record_diag dut_u (.*);
  relay_far_end #(.TICK_GAP(4)) far_u (
    .clock_i (clock_i),
    .tick_o  (sample_tick_i),
    .sample_o(sample_i)
  );

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  function automatic logic [15:0] code_of(input int i);
    int v;
    v = (i < 6) ? i + 1 : (i < 16) ? i + 2 : i + 12;
    return {8'h00, 4'(v / 10), 4'(v % 10)};
  endfunction
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock_i);
  endtask
  // Command pulses, all in one cycle, selected by bits for max, fault, alarm clear.
  task automatic clr(input logic [2:0] which);
    {max_clear_i, fault_clear_i, alarm_clear_i} = which;
    cyc(1);
    {max_clear_i, fault_clear_i, alarm_clear_i} = 3'h0;
    cyc(2);
  endtask
  task automatic power_cycle();
    reset_n_i = 1'b0;
    cyc(12);
    reset_n_i = 1'b1;
    cyc(3);
  endtask
  task automatic trip();
    for (int p = 0; p < 3; p++) meas_i[p].cur = 16'($urandom);
    exp_f = {exp_f[3:0], meas_i[2].cur, meas_i[1].cur, meas_i[0].cur};
    fault_i = 1'b1;
    cyc(1);
    fault_i = 1'b0;
    cyc(1);
    chk(fault_cur_o, exp_f);
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    void'($urandom(25606));
    {fault_i, meas_valid_i, card_present_i, max_clear_i, fault_clear_i, alarm_clear_i} = 6'h00;
    {power_fault_i, prot_out_i, force_i, check_fail_i, meas_i, exp_max, exp_f} = '0;
    {pre_cycles_i, post_cycles_i, wave_rd_entry_i, wave_rd_idx_i} = '0;
    power_cycle();
    clr(3'h7);
    chk({run_lamp_o, alarm_contact_o, lock_o, wave_valid_o}, 8'h80);
    for (int i = 0; i < 26; i++) begin
      prot_out_i = (i < 6) ? 6'h00 : 6'($urandom);
      force_i = (i < 6) ? 6'h01 << i : 6'($urandom);
      cyc(1);
      chk({contact_o, lamp_o}, {2{prot_out_i | force_i}});
    end
    repeat (30) begin
      max_clear_i = ($urandom % 6 == 0);
      meas_valid_i = 1'b1;
      for (int p = 0; p < 3; p++) begin
        meas_i[p] = {16'($urandom % 4000), 8'($urandom)};
        exp_max[p] = (max_clear_i || meas_i[p].cur > exp_max[p]) ? meas_i[p].cur : exp_max[p];
      end
      cyc(1);
      {meas_valid_i, max_clear_i} = 2'h0;
      cyc(1);
      chk(meas_o, meas_i);
      chk(max_cur_o, exp_max);
    end
    clr(3'h4);
    chk(max_cur_o, 48'h0);
    repeat (7) begin
      trip();
      chk(wave_valid_o[0], 1'b0);
    end
    card_present_i = 1'b1;
    for (int k = 0; k < 3; k++) begin
      pre_cycles_i = 8'(pre_t[k]);
      post_cycles_i = 8'(post_t[k]);
      cyc(120);
      trip();
      n = 0;
      while (wave_valid_o[0] !== 1'b1 && n < 200) begin
        cyc(1);
        n++;
      end
      chk(n <= post_t[k] * 48 + 4, 1'b1);
      cyc(1);
      chk(wave_len_o, 12'((pre_t[k] + post_t[k]) * 12));
      // Stored samples are consecutive ticks, phases offset as the far end sends them.
      wave_rd_idx_i = 12'h000;
      cyc(1);
      exp_w = wave_rd_o;
      chk({exp_w[1] - exp_w[0], exp_w[2] - exp_w[0]}, {16'h0001, 16'h0002});
      wave_rd_idx_i = 12'($urandom % ((pre_t[k] + post_t[k]) * 12));
      cyc(1);
      for (int p = 0; p < 3; p++) exp_w[p] = exp_w[p] + 16'(wave_rd_idx_i);
      chk(wave_rd_o, exp_w);
    end
    chk(wave_valid_o, 5'h07);
    wave_rd_entry_i = 3'h2;
    cyc(1);
    chk(wave_len_o, 12'h018);
    wave_rd_entry_i = 3'h3;
    cyc(1);
    chk(wave_len_o, 12'h000);
    power_cycle();
    chk({wave_valid_o, fault_cur_o}, {5'h00, exp_f});
    clr(3'h2);
    chk(fault_cur_o, 240'h0);
    force_i = 6'h3f;
    card_present_i = 1'b0;
    check_fail_i = 21'h010000;
    cyc(1);
    check_fail_i = 21'h0;
    cyc(2);
    chk({lock_o, defect_flags_o}, 22'h0);
    card_present_i = 1'b1;
    for (int i = 20; i >= 0; i--) begin
      check_fail_i = 21'h1 << i;
      cyc(1);
      check_fail_i = 21'h0;
      cyc(2);
      chk({defect_flags_o, defect_code_o}, {21'h1 << i, code_of(i)});
      chk({run_lamp_o, alarm_contact_o, contact_o}, (i > 16) ? 8'hbf : 8'h40);
      clr(3'h1);
      chk(defect_flags_o, 21'h0);
    end
    check_fail_i = 21'h1;
    cyc(1);
    check_fail_i = 21'h2;
    cyc(1);
    check_fail_i = 21'h0;
    power_cycle();
    chk({lock_o, defect_flags_o, defect_code_o}, {1'b0, 21'h3, 16'h0001});
    clr(3'h1);
    power_fault_i = 1'b1;
    cyc(1);
    power_fault_i = 1'b0;
    cyc(1);
    chk({lock_o, contact_o, defect_flags_o}, {1'b1, 6'h00, 21'h0});
    report_and_stop();
  end
endmodule
